// ===== core/fpr_consts.svh
// constants for the fp rounding and nan result block
// assumes a 32-bit ahb-lite register window with byte offsets below 8'h40
`ifndef FPR_CONSTS_SVH
`define FPR_CONSTS_SVH
// register byte offsets
`define FPR_OFF_FPU_CTRL 8'h00
`define FPR_OFF_FPU_STAT 8'h04
`define FPR_OFF_SIMD_CSR 8'h08
`define FPR_OFF_OPA 8'h0C
`define FPR_OFF_OPB 8'h10
`define FPR_OFF_OPADDR 8'h14
`define FPR_OFF_CMD 8'h18
`define FPR_OFF_RESULT 8'h1C
`define FPR_OFF_FAULT_ADDR 8'h20
`define FPR_OFF_STATUS 8'h24
`define FPR_OFF_EXT 8'h28
// field positions
`define FPR_FLAG_LSB 0
`define FPR_FPU_MASK_LSB 0
`define FPR_FPU_RC_LSB 10
`define FPR_SIMD_MASK_LSB 7
`define FPR_SIMD_RC_LSB 13
`define FPR_CMD_UNIT_BIT 0
`define FPR_CMD_OP_LSB 4
`define FPR_CMD_INV_BIT 8
`define FPR_CMD_DZ_BIT 9
`define FPR_CMD_DEN_BIT 10
`define FPR_CMD_TWO_BIT 11
`define FPR_QUIET_BIT 22
// flag bit order inside a six-bit flag or mask group
`define FPR_EX_INV 0
`define FPR_EX_DEN 1
`define FPR_EX_DZ 2
`define FPR_EX_OVF 3
`define FPR_EX_UNF 4
`define FPR_EX_INX 5
// reset values and fixed encodings
`define FPR_FPU_CTRL_RST 32'h0000003F
`define FPR_SIMD_CSR_RST 32'h00001F80
`define FPR_QNAN_INDEF 32'hFFC00000
`define FPR_EXP_MAX 8'hFF
`endif

// ===== core/fpr_pkg.sv
// types shared by the fp rounding and nan result block
// assumes fpr_consts.svh supplies the numeric constants
`default_nettype none
package fpr_pkg;
    // rounding-control field encodings
    typedef enum logic [1:0] {
        FPR_RC_NEAREST = 2'h0,
        FPR_RC_DOWN = 2'h1,
        FPR_RC_UP = 2'h2,
        FPR_RC_ZERO = 2'h3
    } fpr_rc_type;
    // operation codes; codes 2..7 are the truncating conversions
    typedef enum logic [2:0] {
        FPR_OP_ARITH = 3'h0,
        FPR_OP_COMPARE = 3'h1,
        FPR_OP_TRUNC_PD2DQ = 3'h2,
        FPR_OP_TRUNC_PS2DQ = 3'h3,
        FPR_OP_TRUNC_PD2MM = 3'h4,
        FPR_OP_TRUNC_PS2MM = 3'h5,
        FPR_OP_TRUNC_SD2INT = 3'h6,
        FPR_OP_TRUNC_SS2INT = 3'h7
    } fpr_op_type;
    // bus slave data-phase states, gray along idle-rdwait-rddone and idle-write
    typedef enum logic [1:0] {
        FPR_BUS_IDLE = 2'h0,
        FPR_BUS_WRITE = 2'h2,
        FPR_BUS_RDWAIT = 2'h1,
        FPR_BUS_RDDONE = 2'h3
    } fpr_bus_type;
endpackage
`default_nettype wire

// ===== core/fpr_round_dec.sv
// rounding decision: whether to bump the retained lsb
// assumes guard and sticky bits of the exact value are given
`timescale 1ns/10ps
`default_nettype none
module fpr_round_dec (
    input wire logic [1:0] mode,
    input wire logic sign,
    input wire logic lsb,
    input wire logic guard,
    input wire logic sticky,
    output logic inc,
    output logic inexact
);
    // pick lower or upper neighbour of the exact value
    always_comb
    begin
        inexact = guard | sticky;
        case (fpr_pkg::fpr_rc_type'(mode))
            fpr_pkg::FPR_RC_NEAREST: inc = guard & (sticky | lsb);
            fpr_pkg::FPR_RC_DOWN: inc = sign & inexact;
            fpr_pkg::FPR_RC_UP: inc = ~sign & inexact;
            fpr_pkg::FPR_RC_ZERO: inc = 1'b0;
            default: inc = 1'b0;
        endcase
    end
endmodule // fpr_round_dec
`default_nettype wire

// ===== core/fpr_nan_sel.sv
// nan propagation for one or two single-precision sources
// assumes the caller already knows whether the op is scalar-stack or simd
`timescale 1ns/10ps
`default_nettype none
`include "fpr_consts.svh"
module fpr_nan_sel (
    input wire logic [31:0] opa,
    input wire logic [31:0] opb,
    input wire logic two_op,
    input wire logic simd,
    output logic [31:0] result,
    output logic any_nan,
    output logic any_snan
);
    // nan: max exponent with nonzero fraction, sign ignored
    function automatic logic f_is_nan(input logic [31:0] v);
        f_is_nan = (v[30:23] == `FPR_EXP_MAX) && (v[22:0] != 23'h000000);
    endfunction
    // signalling when the top fraction bit is clear
    function automatic logic f_is_snan(input logic [31:0] v);
        f_is_snan = f_is_nan(v) && !v[`FPR_QUIET_BIT];
    endfunction
    logic a_nan, b_nan, a_sn, b_sn;
    logic [31:0] qa, qb;
    // quieting sets one bit only, so payloads survive
    assign qa = opa | (32'h1 << `FPR_QUIET_BIT);
    assign qb = opb | (32'h1 << `FPR_QUIET_BIT);
    assign a_nan = f_is_nan(opa);
    assign b_nan = two_op && f_is_nan(opb);
    assign a_sn = f_is_snan(opa);
    assign b_sn = two_op && f_is_snan(opb);
    assign any_nan = a_nan | b_nan;
    assign any_snan = a_sn | b_sn;
    // simd takes the first nan; stack prefers quiet, then larger payload
    always_comb
    begin
        if (simd)
            result = a_nan ? qa : qb;
        else if (a_nan && b_nan && (a_sn != b_sn))
            result = a_sn ? opb : opa;
        else if (a_nan && b_nan)
            result = (opa[22:0] >= opb[22:0]) ? qa : qb;
        else
            result = a_nan ? qa : qb;
    end
endmodule // fpr_nan_sel
`default_nettype wire

// ===== core/fpr_top.sv
// fp rounding and nan result engine behind an ahb-lite register window
// assumes a single ahb-lite master, whole-word transfers, one clock
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "fpr_consts.svh"
module fpr_top #(
    parameter int ADDR_W = 8 // decoded address bits
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic exc_trap // level: an unmasked exception awaits service
);
    // bus slave state
    fpr_pkg::fpr_bus_type bus_state; // data-phase tracking
    fpr_pkg::fpr_bus_type next_bus_state;
    logic [ADDR_W-1:0] dp_addr; // address latched in address phase
    logic addr_take; // an address phase is accepted this edge
    logic wr_en; // data-phase write strobe
    logic [31:0] rd_mux; // register selected for reading
    // software-visible registers
    logic [5:0] fpu_mask; // stack unit exception masks
    logic [1:0] fpu_rc; // stack unit rounding_control_field
    logic [5:0] fpu_flag; // stack unit sticky flags
    logic [5:0] simd_flag; // simd sticky flags
    logic [5:0] simd_mask; // simd exception masks
    logic [1:0] simd_rc; // simd rounding_control_field
    logic [31:0] opa; // first operand / exact value
    logic [31:0] opb; // second operand
    logic [31:0] op_ext; // exact bits below the retained lsb
    logic [31:0] opaddr; // memory address of the first operand
    logic [11:0] cmd; // latched command word
    logic [31:0] result; // delivered result
    logic [31:0] fault_addr; // operand address captured at trap
    logic trap; // pending unmasked exception
    logic exec_go; // execute slot follows a command write
    // execute-stage combinational values
    logic ex_simd, ex_two, ex_trunc, ex_cmp;
    fpr_pkg::fpr_op_type ex_op;
    logic [1:0] ex_mode; // rounding mode in force this cycle
    logic [5:0] ex_mask;
    logic [31:0] nan_res;
    logic any_nan, any_snan;
    logic rnd_inc, rnd_inexact;
    logic [30:0] mag_sum; // exponent and fraction after increment
    logic [5:0] ex_flags; // exceptions raised by this operation
    logic [31:0] ex_result;
    logic ex_unmasked; // some raised exception is unmasked
    logic ex_precomp_trap; // trap before any result is formed

    // address phase acceptance; no accept while a read is waiting
    assign addr_take = hsel && htrans[1] && hready &&
        (bus_state != fpr_pkg::FPR_BUS_RDWAIT);
    assign wr_en = (bus_state == fpr_pkg::FPR_BUS_WRITE);
    // one wait state only on reads, so read data come from a register
    assign hreadyout = (bus_state != fpr_pkg::FPR_BUS_RDWAIT);
    assign hresp = 1'b0;
    assign exc_trap = trap;

    // next data-phase state
    always_comb
    begin
        case (bus_state)
            fpr_pkg::FPR_BUS_RDWAIT: next_bus_state = fpr_pkg::FPR_BUS_RDDONE;
            fpr_pkg::FPR_BUS_IDLE,
            fpr_pkg::FPR_BUS_WRITE,
            fpr_pkg::FPR_BUS_RDDONE:
            begin
                if (!addr_take)
                    next_bus_state = fpr_pkg::FPR_BUS_IDLE;
                else if (hwrite)
                    next_bus_state = fpr_pkg::FPR_BUS_WRITE;
                else
                    next_bus_state = fpr_pkg::FPR_BUS_RDWAIT;
            end
            default: next_bus_state = fpr_pkg::FPR_BUS_IDLE;
        endcase
    end

    // bus state and latched address
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_state <= fpr_pkg::FPR_BUS_IDLE;
            dp_addr <= '0;
        end
        else
        begin
            bus_state <= next_bus_state;
            if (addr_take)
                dp_addr <= haddr[ADDR_W-1:0];
        end
    end

    // read multiplexer; unmapped offsets read zero
    always_comb
    begin
        case (dp_addr)
            `FPR_OFF_FPU_CTRL: rd_mux = {20'h00000, fpu_rc, 4'h0, fpu_mask};
            `FPR_OFF_FPU_STAT: rd_mux = {26'h0000000, fpu_flag};
            `FPR_OFF_SIMD_CSR:
                rd_mux = {17'h00000, simd_rc, simd_mask, 1'b0, simd_flag};
            `FPR_OFF_OPA: rd_mux = opa;
            `FPR_OFF_OPB: rd_mux = opb;
            `FPR_OFF_OPADDR: rd_mux = opaddr;
            `FPR_OFF_CMD: rd_mux = {20'h00000, cmd};
            `FPR_OFF_RESULT: rd_mux = result;
            `FPR_OFF_FAULT_ADDR: rd_mux = fault_addr;
            `FPR_OFF_STATUS: rd_mux = {30'h00000000, exec_go, trap};
            `FPR_OFF_EXT: rd_mux = op_ext;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data register, loaded during the wait state
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            hrdata <= 32'h00000000;
        else if (bus_state == fpr_pkg::FPR_BUS_RDWAIT)
            hrdata <= rd_mux;
    end

    // execute-stage decode from the latched command
    assign ex_simd = cmd[`FPR_CMD_UNIT_BIT];
    assign ex_two = cmd[`FPR_CMD_TWO_BIT];
    assign ex_op = fpr_pkg::fpr_op_type'(cmd[`FPR_CMD_OP_LSB +: 3]);
    assign ex_cmp = (ex_op == fpr_pkg::FPR_OP_COMPARE);
    assign ex_trunc = (ex_op != fpr_pkg::FPR_OP_ARITH) && !ex_cmp;
    assign ex_mask = ex_simd ? simd_mask : fpu_mask;
    // truncating conversions force round toward zero; other ops read their own unit's field, live at execute time
    always_comb
    begin
        if (ex_trunc)
            ex_mode = 2'(fpr_pkg::FPR_RC_ZERO);
        else if (ex_simd)
            ex_mode = simd_rc;
        else
            ex_mode = fpu_rc;
    end

    // nan selection between the two sources
    fpr_nan_sel u_nan (
        .opa(opa),
        .opb(opb),
        .two_op(ex_two),
        .simd(ex_simd),
        .result(nan_res),
        .any_nan(any_nan),
        .any_snan(any_snan)
    );

    // rounding decision on the bits below the retained lsb
    fpr_round_dec u_rnd (
        .mode(ex_mode),
        .sign(opa[31]),
        .lsb(opa[0]),
        .guard(op_ext[31]),
        .sticky(|op_ext[30:0]),
        .inc(rnd_inc),
        .inexact(rnd_inexact)
    );

    // a carry out of the fraction steps the exponent, never past one ulp
    assign mag_sum = opa[30:0] + {30'h00000000, rnd_inc};

    // result and exception classification for one operation
    always_comb
    begin
        ex_flags = 6'h00;
        ex_result = opa;
        if (cmd[`FPR_CMD_DEN_BIT])
            ex_flags[`FPR_EX_DEN] = 1'b1;
        if (any_nan)
        begin
            // nan results ignore the mode and are never inexact
            ex_result = nan_res;
            ex_flags[`FPR_EX_INV] = any_snan;
        end
        else if (cmd[`FPR_CMD_INV_BIT])
        begin
            ex_result = `FPR_QNAN_INDEF;
            ex_flags[`FPR_EX_INV] = 1'b1;
        end
        else if (cmd[`FPR_CMD_DZ_BIT])
        begin
            ex_result = {opa[31] ^ opb[31], `FPR_EXP_MAX, 23'h000000};
            ex_flags[`FPR_EX_DZ] = 1'b1;
        end
        else if (ex_cmp)
            ex_result = {31'h00000000, opa == opb};
        else
        begin
            // exact values pass unchanged since inc needs a dropped bit
            ex_result = {opa[31], mag_sum};
            ex_flags[`FPR_EX_INX] = rnd_inexact;
            if (rnd_inexact && mag_sum[30:23] == `FPR_EXP_MAX)
                ex_flags[`FPR_EX_OVF] = 1'b1;
            if (rnd_inexact && mag_sum[30:23] == 8'h00)
                ex_flags[`FPR_EX_UNF] = 1'b1;
        end
    end

    // an unmasked condition diverts to the handler
    assign ex_unmasked = |(ex_flags & ~ex_mask);
    // invalid, divide and denormal stop before a result is stored
    assign ex_precomp_trap = |(ex_flags & ~ex_mask & 6'h07);

    // stack unit control register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fpu_mask <= 6'(`FPR_FPU_CTRL_RST >> `FPR_FPU_MASK_LSB);
            fpu_rc <= 2'(fpr_pkg::FPR_RC_NEAREST);
        end
        else if (wr_en && dp_addr == `FPR_OFF_FPU_CTRL)
        begin
            fpu_mask <= hwdata[`FPR_FPU_MASK_LSB +: 6];
            fpu_rc <= hwdata[`FPR_FPU_RC_LSB +: 2];
        end
    end

    // stack unit sticky flags; a new event beats a write-one clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            fpu_flag <= 6'h00;
        else
        begin
            if (wr_en && dp_addr == `FPR_OFF_FPU_STAT)
                fpu_flag <= (fpu_flag & ~hwdata[5:0]) |
                    ((exec_go && !ex_simd) ? ex_flags : 6'h00);
            else if (exec_go && !ex_simd)
                fpu_flag <= fpu_flag | ex_flags;
        end
    end

    // simd control and status register
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            simd_flag <= 6'h00;
            simd_mask <= 6'(`FPR_SIMD_CSR_RST >> `FPR_SIMD_MASK_LSB);
            simd_rc <= 2'(fpr_pkg::FPR_RC_NEAREST);
        end
        else
        begin
            if (wr_en && dp_addr == `FPR_OFF_SIMD_CSR)
            begin
                simd_mask <= hwdata[`FPR_SIMD_MASK_LSB +: 6];
                simd_rc <= hwdata[`FPR_SIMD_RC_LSB +: 2];
                simd_flag <= (simd_flag & ~hwdata[5:0]) |
                    ((exec_go && ex_simd) ? ex_flags : 6'h00);
            end
            else if (exec_go && ex_simd)
                simd_flag <= simd_flag | ex_flags;
        end
    end

    // operand registers; a simd result overwrites the first operand
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opa <= 32'h00000000;
            opb <= 32'h00000000;
            op_ext <= 32'h00000000;
            opaddr <= 32'h00000000;
        end
        else
        begin
            // a bus write in the execute cycle is newer, so it wins
            if (wr_en && dp_addr == `FPR_OFF_OPA)
                opa <= hwdata;
            else if (exec_go && ex_simd && !ex_precomp_trap)
                opa <= ex_result;
            if (wr_en && dp_addr == `FPR_OFF_OPB)
                opb <= hwdata;
            if (wr_en && dp_addr == `FPR_OFF_EXT)
                op_ext <= hwdata;
            if (wr_en && dp_addr == `FPR_OFF_OPADDR)
                opaddr <= hwdata;
        end
    end

    // command latch and execute slot
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd <= 12'h000;
            exec_go <= 1'b0;
        end
        else
        begin
            exec_go <= wr_en && dp_addr == `FPR_OFF_CMD;
            if (wr_en && dp_addr == `FPR_OFF_CMD)
                cmd <= hwdata[11:0];
        end
    end

    // delivered result; untouched when a pre-computation trap fires
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            result <= 32'h00000000;
        else if (exec_go && !ex_precomp_trap)
            result <= ex_result;
    end

    // trap flag and faulting operand address
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trap <= 1'b0;
            fault_addr <= 32'h00000000;
        end
        else
        begin
            if (exec_go && ex_unmasked)
                trap <= 1'b1;
            else if (wr_en && dp_addr == `FPR_OFF_STATUS && hwdata[0])
                trap <= 1'b0;
            if (exec_go && ex_unmasked)
                fault_addr <= opaddr;
        end
    end
endmodule // fpr_top
`default_nettype wire

// ===== verif/fpr_top_asserts.sv
// bus and trap timing checks for the fp result engine
// assumes hready is the engine's own hreadyout
`timescale 1ns/10ps
`default_nettype none
`include "fpr_consts.svh"
module fpr_top_asserts (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic exc_trap
);
    logic acc_rd; // read address phase taken
    logic acc_wr; // write address phase taken
    logic acc_cmd; // command write taken
    logic acc_stat; // status write taken
    assign acc_rd = hsel & htrans[1] & hready & ~hwrite;
    assign acc_wr = hsel & htrans[1] & hready & hwrite;
    assign acc_cmd = acc_wr & (haddr[7:0] == `FPR_OFF_CMD);
    assign acc_stat = acc_wr & (haddr[7:0] == `FPR_OFF_STATUS);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    chk_read_wait: assert property (acc_rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    chk_write_nowait: assert property (acc_wr |=> hreadyout)
        else $error("write stalled");
    chk_wait_cause: assert property ($fell(hreadyout) |-> $past(acc_rd))
        else $error("wait state without read");
    chk_rdata_load: assert property (!$stable(hrdata) |-> $past(acc_rd, 2))
        else $error("read data moved outside a read");
    chk_unmapped_zero: assert property
        (acc_rd && haddr[7:0] > 8'h28 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_trap_rise: assert property
        ($rose(exc_trap) |-> $past(acc_cmd, 3))
        else $error("trap rose without execution");
    chk_trap_fall: assert property
        ($fell(exc_trap) |-> $past(acc_stat, 2))
        else $error("trap fell without clear");
endmodule // fpr_top_asserts
bind fpr_top fpr_top_asserts u_chk (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .exc_trap(exc_trap)
);
`default_nettype wire

// ===== verif/fpr_pipe_model.sv
// pipeline model: single-word ahb-lite master feeding the engine
// assumes hready is the engine's hreadyout, one clock
`timescale 1ns/10ps
`default_nettype none
module fpr_pipe_model (
    input wire logic sys_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic tmo
);
    logic rdy_s; // hready as it stands before the next edge
    logic [31:0] rdat_s; // read data as it stands before the next edge
    // idle bus at time zero
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tmo = 1'b0;
    end
    // mid-cycle copy so a rising edge never races the slave's update
    always @(negedge sys_clk)
    begin
        rdy_s <= hready;
        rdat_s <= hrdata;
    end
    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (rdy_s !== 1'b1 && n < 64);
        if (rdy_s !== 1'b1)
            tmo <= 1'b1;
    endtask
    // one whole-word transfer; released lines show inverted junk
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~{24'h0, a};
        hwdata <= d;
        wait_rdy();
        r = rdat_s;
        hwdata <= ~d;
    endtask
endmodule // fpr_pipe_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the fp rounding and nan result engine
// assumes the pipeline model is the only bus master
`timescale 1ns/10ps
`default_nettype none
`include "fpr_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end end
module tb;
    logic sys_clk;
    logic arst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic exc_trap;
    logic tmo;
    int mismatches;
    int comparisons;
    logic [31:0] simd_csr; // shadow of simd csr control bits
    logic [31:0] res;
    logic [31:0] fl;
    fpr_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .exc_trap(exc_trap));
    fpr_pipe_model u_pipe (.sys_clk(sys_clk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .tmo(tmo));
    // 25 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_pipe.xfer(a, 1'b1, d, res);
    endtask
    task automatic rd(input logic [7:0] a);
        u_pipe.xfer(a, 1'b0, 32'h0, res);
    endtask
    // expected {inexact, underflow, overflow, 000, result}
    function automatic logic [37:0] rnd(input logic [1:0] rc,
        input logic [31:0] a, input logic [31:0] x);
        logic nz;
        logic inc;
        logic [31:0] r;
        nz = |x;
        case (rc)
            2'h0: inc = x[31] & ((|x[30:0]) | a[0]);
            2'h1: inc = a[31] & nz;
            2'h2: inc = ~a[31] & nz;
            default: inc = 1'b0;
        endcase
        r = a + {31'h0, inc};
        return {nz, nz && r[30:23] == 8'h00, nz && r[30:23] == 8'hFF,
            3'h0, r};
    endfunction
    // load operands, clear flags, execute, judge result and flags
    task automatic one(input logic [11:0] cmd, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] x,
        input logic [31:0] er, input logic [5:0] ef);
        wr(`FPR_OFF_OPA, a);
        wr(`FPR_OFF_OPB, b);
        wr(`FPR_OFF_EXT, x);
        wr(`FPR_OFF_FPU_STAT, 32'h0000003F);
        wr(`FPR_OFF_SIMD_CSR, simd_csr | 32'h0000003F);
        wr(`FPR_OFF_CMD, {20'h0, cmd});
        rd(`FPR_OFF_RESULT);
        fl = res;
        rd(cmd[0] ? `FPR_OFF_SIMD_CSR : `FPR_OFF_FPU_STAT);
        `CHK(fl, er)
        `CHK(res[5:0], ef)
    endtask
    task automatic t_reset();
        rd(`FPR_OFF_FPU_CTRL);
        `CHK(res, 32'h0000003F)
        rd(`FPR_OFF_SIMD_CSR);
        `CHK(res, 32'h00001F80)
        rd(8'h3C);
        `CHK(res, 32'h0)
        wr(`FPR_OFF_RESULT, 32'hDEADBEEF);
        rd(`FPR_OFF_RESULT);
        `CHK(res, 32'h0)
        `CHK(exc_trap, 1'b0)
    endtask
    // every mode on ties, near-ties, exact, overflow and underflow
    task automatic t_round();
        logic [31:0] a [6];
        logic [31:0] x [6];
        logic [37:0] e;
        a = '{32'h3F800001, 32'h3F800000, 32'hBF800000, 32'h3F800000,
            32'h7F7FFFFF, 32'h00000001};
        x = '{32'h80000000, 32'h80000000, 32'h40000000, 32'h0,
            32'h80000000, 32'hC0000000};
        for (int rc = 0; rc < 4; rc++)
        begin
            wr(`FPR_OFF_FPU_CTRL, {20'h0, rc[1:0], 10'h03F});
            for (int i = 0; i < 6; i++)
            begin
                e = rnd(rc[1:0], a[i], x[i]);
                one(12'h0, a[i], 32'h0, x[i], e[31:0],
                    e[37:32]);
            end
        end
    endtask
    // simd up, stack down, then the truncating conversions
    task automatic t_units();
        simd_csr = 32'h00005F80;
        wr(`FPR_OFF_FPU_CTRL, 32'h0000043F);
        one(12'h001, 32'h3F800000, 32'h0, 32'h40000000,
            32'h3F800001, 6'h20);
        rd(`FPR_OFF_OPA);
        `CHK(res, 32'h3F800001)
        one(12'h000, 32'h3F800000, 32'h0, 32'h40000000,
            32'h3F800000, 6'h20);
        for (int op = 2; op < 8; op++)
            one({5'h0, op[2:0], 4'h1}, 32'h3F800000, 32'h0,
                32'h40000000, 32'h3F800000, 6'h20);
    endtask
    task automatic t_nan();
        wr(`FPR_OFF_FPU_CTRL, 32'h0000083F);
        one(12'h000, 32'h7F800123, 32'h0, 32'h0,
            32'h7FC00123, 6'h01);
        one(12'h000, 32'h7FC00055, 32'h0, 32'h80000000,
            32'h7FC00055, 6'h00);
        // compare under round-up: equality only, no bump, no flags
        one(12'h810, 32'h3F800000, 32'h3F800000, 32'h80000000,
            32'h00000001, 6'h00);
        one(12'h100, 32'h3F800000, 32'h0, 32'h0,
            32'hFFC00000, 6'h01);
        one(12'hA00, 32'h3F800000, 32'h80000000, 32'h0,
            32'hFF800000, 6'h04);
        one(12'h400, 32'h00400000, 32'h0, 32'h0,
            32'h00400000, 6'h02);
        one(12'h800, 32'h7F800001, 32'h7F800009, 32'h0,
            32'h7FC00009, 6'h01);
        one(12'h801, 32'h7F800001, 32'h7F800009, 32'h0,
            32'h7FC00001, 6'h01);
    endtask
    // unmasked invalid on a signalling source traps and keeps result
    task automatic t_trap();
        wr(`FPR_OFF_FPU_CTRL, 32'h0000003E);
        wr(`FPR_OFF_OPADDR, 32'h0000A5C0);
        one(12'h000, 32'h40000000, 32'h0, 32'h0, 32'h40000000, 6'h00);
        one(12'h000, 32'h7F800123, 32'h0, 32'h0,
            32'h40000000, 6'h01);
        `CHK(exc_trap, 1'b1)
        rd(`FPR_OFF_FAULT_ADDR);
        `CHK(res, 32'h0000A5C0)
        rd(`FPR_OFF_STATUS);
        `CHK(res[0], 1'b1)
        wr(`FPR_OFF_STATUS, 32'h00000001);
        @(negedge sys_clk);
        `CHK(exc_trap, 1'b0)
        wr(`FPR_OFF_FPU_CTRL, 32'h0000003F);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // a stuck handshake ends the run as a failure
    always @(posedge tmo)
    begin
        mismatches++;
        test_done();
    end
    initial
    begin
        mismatches = 0;
        comparisons = 0;
        simd_csr = 32'h00001F80;
        arst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset();
        t_round();
        t_units();
        t_nan();
        t_trap();
        test_done();
    end
endmodule // tb
`default_nettype wire
